// ==== verilog/adcsm_map.vh ====
`ifndef ADCSM_MAP_VH
`define ADCSM_MAP_VH
// register word indices and byte addresses
`define ADCSM_IDX_STATUS 8'h01
`define ADCSM_IDX_MODE 8'h02
`define ADCSM_ADDR_STATUS 8'h04
`define ADCSM_ADDR_MODE 8'h08
// status field positions
`define ADCSM_ST_LOCK 15
`define ADCSM_ST_RESYNC 14
`define ADCSM_ST_REGMAP 13
`define ADCSM_ST_CRCERR 12
`define ADCSM_ST_CRCTYPE 11
`define ADCSM_ST_RESET 10
// mode field positions
`define ADCSM_MD_REGCRC 13
`define ADCSM_MD_RXCRC 12
`define ADCSM_MD_CRCTYPE 11
`define ADCSM_MD_RESET 10
`define ADCSM_MD_TIMEOUT 4
// reset values and writable mask
`define ADCSM_STATUS_RST 16'h0500
`define ADCSM_MODE_RST 16'h0510
`define ADCSM_MODE_WMASK 16'h3f1f
`define ADCSM_MODE_RST_LO 8'h10
`define ADCSM_MODE_RST_HI 8'h05
`define ADCSM_MODE_WMASK_LO 8'h1f
`define ADCSM_MODE_WMASK_HI 8'h3f
`define ADCSM_WLEN_RST 2'h1
`endif

// ==== verilog/adcsm_regs.v ====
`include "adcsm_map.vh"
`timescale 1ns/100ps
`default_nettype none
module adcsm_regs (
	input wire ref_clk, // 10 MHz clock
	input wire resetn, // async reset, active low
	input wire [7:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write byte enables
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [7:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire if_locked, // interface lock level
	input wire resync_pulse, // resynchronization event
	input wire regmap_crc_changed, // map checksum change event
	input wire rx_crc_error, // input checksum error event
	input wire [5:0] new_data_set, // per channel new data event
	input wire [5:0] new_data_clr, // per channel data read
	input wire status_read_clr, // status frame read, clears resync and checksum flags
	output reg reg_crc_en, // map checksum enable
	output reg rx_crc_en, // input checksum enable
	output reg crc_type_sel, // polynomial select
	output reg [1:0] word_length_sel, // data word length
	output reg timeout_en // interface timeout enable
);

	// reset release through two flops
	reg rst_meta_q;
	reg rst_n_q;
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	reg [15:0] mode_q;
	reg lock_q;
	reg resync_occurred_flag_q;
	reg regmap_flag_q;
	reg crcerr_flag_q;
	reg reset_flag_q;
	reg [5:0] new_data_q;
	reg [7:0] aw_addr_q;
	reg aw_have_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg w_have_q;

	// write when both halves captured and no response pending
	wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	wire wr_mode = wr_fire && (aw_addr_q == `ADCSM_ADDR_MODE);
	wire wr_lo = wr_mode && w_strb_q[0];
	wire wr_hi = wr_mode && w_strb_q[1];
	wire clr_reset = wr_hi && !w_data_q[`ADCSM_MD_RESET];

	// checksum events only count while their check is enabled
	wire regmap_evt = regmap_crc_changed && mode_q[`ADCSM_MD_REGCRC];
	wire rxcrc_evt = rx_crc_error && mode_q[`ADCSM_MD_RXCRC];

	// composed status word, field by field, reserved bits zero
	reg [15:0] status_word;
	always @*
	begin
		status_word = 16'h0000;
		status_word[`ADCSM_ST_LOCK] = lock_q;
		status_word[`ADCSM_ST_RESYNC] = resync_occurred_flag_q;
		status_word[`ADCSM_ST_REGMAP] = regmap_flag_q;
		status_word[`ADCSM_ST_CRCERR] = crcerr_flag_q;
		status_word[`ADCSM_ST_CRCTYPE] = mode_q[`ADCSM_MD_CRCTYPE];
		status_word[`ADCSM_ST_RESET] = reset_flag_q;
		status_word[9:8] = mode_q[9:8];
		status_word[5:0] = new_data_q;
	end

	// write response code: status is read only, unmapped is a decode error
	reg [1:0] wr_resp;
	always @*
	begin
		case (aw_addr_q)
			`ADCSM_ADDR_MODE:
				wr_resp = 2'h0;
			`ADCSM_ADDR_STATUS:
				wr_resp = 2'h2;
			default:
				wr_resp = 2'h3;
		endcase
	end

	// write channel capture
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			aw_addr_q <= 8'h00;
			aw_have_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			w_have_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
				aw_have_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_resp;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// mode low byte, reserved bits 7:5 forced to zero
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			mode_q[7:0] <= `ADCSM_MODE_RST_LO;
		else if (wr_lo)
			mode_q[7:0] <= w_data_q[7:0] & `ADCSM_MODE_WMASK_LO;
	end

	// mode high byte, reserved bits 15:14 forced to zero
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			mode_q[15:8] <= `ADCSM_MODE_RST_HI;
		else if (wr_hi)
			mode_q[15:8] <= w_data_q[15:8] & `ADCSM_MODE_WMASK_HI;
	end

	// map checksum enable out to the converter
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			reg_crc_en <= 1'b0;
		else
			reg_crc_en <= mode_q[`ADCSM_MD_REGCRC];
	end

	// input checksum enable out to the converter
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			rx_crc_en <= 1'b0;
		else
			rx_crc_en <= mode_q[`ADCSM_MD_RXCRC];
	end

	// one polynomial select shared by both checksums
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			crc_type_sel <= 1'b0;
		else
			crc_type_sel <= mode_q[`ADCSM_MD_CRCTYPE];
	end

	// data word length out to the converter
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			word_length_sel <= `ADCSM_WLEN_RST;
		else
			word_length_sel <= mode_q[9:8];
	end

	// interface timeout enable out
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			timeout_en <= 1'b1;
		else
			timeout_en <= mode_q[`ADCSM_MD_TIMEOUT];
	end

	// interface lock level, one cycle behind its input
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			lock_q <= 1'b0;
		else
			lock_q <= if_locked;
	end

	// resync flag; a set in the clearing cycle wins
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			resync_occurred_flag_q <= 1'b0;
		else if (resync_pulse)
			resync_occurred_flag_q <= 1'b1;
		else if (status_read_clr)
			resync_occurred_flag_q <= 1'b0;
	end

	// map checksum change flag; set wins over clear
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			regmap_flag_q <= 1'b0;
		else if (regmap_evt)
			regmap_flag_q <= 1'b1;
		else if (status_read_clr)
			regmap_flag_q <= 1'b0;
	end

	// input checksum error flag; set wins over clear
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			crcerr_flag_q <= 1'b0;
		else if (rxcrc_evt)
			crcerr_flag_q <= 1'b1;
		else if (status_read_clr)
			crcerr_flag_q <= 1'b0;
	end

	// reset occurred flag, only a reset sets it again
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			reset_flag_q <= 1'b1;
		else if (clr_reset)
			reset_flag_q <= 1'b0;
	end

	// per channel new data flags
	genvar ch;
	generate
		for (ch = 0; ch < 6; ch = ch + 1)
		begin : g_ch
			always @(posedge ref_clk or negedge rst_n_q)
			begin
				if (!rst_n_q)
					new_data_q[ch] <= 1'b0;
				else if (new_data_set[ch])
					new_data_q[ch] <= 1'b1;
				else if (new_data_clr[ch])
					new_data_q[ch] <= 1'b0;
			end
		end
	endgenerate

	// read channel
	always @(posedge ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				case ({s_axi_araddr[7:2], 2'h0})
					`ADCSM_ADDR_STATUS:
					begin
						s_axi_rdata <= {16'h0000, status_word};
						s_axi_rresp <= 2'h0;
					end
					`ADCSM_ADDR_MODE:
					begin
						s_axi_rdata <= {16'h0000, mode_q};
						s_axi_rresp <= 2'h0;
					end
					default:
					begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h3;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== verif/adcsm_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module adcsm_monitor (
	input wire ref_clk, // clk
	input wire resetn, // rst
	input wire [7:0] s_axi_awaddr, // aw
	input wire s_axi_awvalid, // aw
	input wire s_axi_awready, // aw
	input wire [31:0] s_axi_wdata, // w
	input wire [3:0] s_axi_wstrb, // w
	input wire s_axi_wvalid, // w
	input wire s_axi_wready, // w
	input wire [1:0] s_axi_bresp, // b
	input wire s_axi_bvalid, // b
	input wire [7:0] s_axi_araddr, // ar
	input wire s_axi_arvalid, // ar
	input wire s_axi_arready, // ar
	input wire [31:0] s_axi_rdata, // r
	input wire if_locked, // lock
	input wire reg_crc_en, // out
	input wire rx_crc_en, // out
	input wire crc_type_sel, // out
	input wire [1:0] word_length_sel, // out
	input wire timeout_en // out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// handshakes on the mode and status words
	wire wh = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire b1 = wh && s_axi_awaddr == 8'h08 && s_axi_wstrb[1];
	wire b0 = wh && s_axi_awaddr == 8'h08 && s_axi_wstrb[0];
	wire ws = s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h04;
	wire rs = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04;
	property p_rce; b1 |-> ##3 reg_crc_en == $past(s_axi_wdata[13], 3); endproperty
	a_rce: assert property (p_rce) else $error("map crc enable wrong");
	property p_xce; b1 |-> ##3 rx_crc_en == $past(s_axi_wdata[12], 3); endproperty
	a_xce: assert property (p_xce) else $error("input crc enable wrong");
	property p_pol; b1 |-> ##3 crc_type_sel == $past(s_axi_wdata[11], 3); endproperty
	a_pol: assert property (p_pol) else $error("polynomial wrong");
	property p_wl; b1 |-> ##3 word_length_sel == $past(s_axi_wdata[9:8], 3); endproperty
	a_wl: assert property (p_wl) else $error("word length wrong");
	property p_to; b0 |-> ##3 timeout_en == $past(s_axi_wdata[4], 3); endproperty
	a_to: assert property (p_to) else $error("timeout enable wrong");
	property p_ro; ws |-> ##[1:4] s_axi_bvalid && s_axi_bresp == 2'h2; endproperty
	a_ro: assert property (p_ro) else $error("status write not refused");
	property p_lk; rs && if_locked == $past(if_locked) |=> s_axi_rdata[15] == $past(if_locked);
	endproperty
	a_lk: assert property (p_lk) else $error("lock bit wrong");
	property p_mir; rs |=> s_axi_rdata[11] == crc_type_sel && s_axi_rdata[9:8] == word_length_sel;
	endproperty
	a_mir: assert property (p_mir) else $error("status mirror wrong");
endmodule
bind adcsm_regs adcsm_monitor mon (.*);
`default_nettype wire

// ==== verif/adcsm_evt.sv ====
`timescale 1ns/100ps
`default_nettype none
module adcsm_evt (
	input wire ref_clk, // clk
	input wire go, // fire
	input wire [8:0] pat, // events
	output logic [8:0] ev // pulses
);
	// one-cycle event pulses, low otherwise
	always @(posedge ref_clk)
	begin
		ev <= go ? pat : 9'h000;
	end
endmodule
`default_nettype wire

// ==== verif/adcsm_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module adcsm_regs_test;
	logic ref_clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
	logic s_axi_arvalid = 0, s_axi_rready = 1, if_locked = 0, status_read_clr = 0, go = 0, rf;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, seed = 32'h00000024, r;
	logic [3:0] s_axi_wstrb = 0;
	logic [5:0] new_data_clr = 0;
	logic [8:0] pat = 0, ev;
	logic [15:0] md;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire reg_crc_en, rx_crc_en, crc_type_sel, timeout_en;
	wire [1:0] s_axi_bresp, s_axi_rresp, word_length_sel;
	wire [31:0] s_axi_rdata;
	int fail_count = 0, cmp_count = 0, i, n;
	// block under test and its event source
	adcsm_regs uut (.*, .resync_pulse(ev[0]), .regmap_crc_changed(ev[1]), .rx_crc_error(ev[2]),
		.new_data_set(ev[8:3]));
	adcsm_evt src (.*);
	// 100 ns clock
	always #50 ref_clk = ~ref_clk;
	// xorshift source
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected status word after one event burst
	function logic [15:0] st_exp(input logic [15:0] m);
		return {r[16], pat[0], pat[1] & m[13], pat[2] & m[12], m[11], rf, m[9:8], 2'h0, pat[8:3]};
	endfunction
	task test_done(input int t);
		fail_count += t;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one write, address and data offered together
	task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			n++;
		end
		while (n < 50 && s_axi_bvalid !== 1);
		if (n == 50) test_done(1);
		`CHK("bresp", e, s_axi_bresp)
	endtask
	// one read, response and data compared
	task rd(input logic [7:0] a, input logic [1:0] e, input logic [15:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			n++;
		end
		while (n < 50 && s_axi_rvalid !== 1);
		if (n == 50) test_done(1);
		`CHK("read", {e, 16'h0000, d}, {s_axi_rresp, s_axi_rdata})
	endtask
	// reset values, refusals, then random mode and event rounds
	initial
	begin
		rf = 1;
		repeat (20) @(posedge ref_clk);
		resetn <= 1;
		repeat (4) @(posedge ref_clk);
		`CHK("outs", 6'h03, {reg_crc_en, rx_crc_en, crc_type_sel, word_length_sel, timeout_en})
		rd(8'h04, 2'h0, 16'h0500);
		rd(8'h08, 2'h0, 16'h0510);
		wr(8'h04, 16'hffff, 2'h2);
		rd(8'h0c, 2'h3, 16'h0000);
		wr(8'h08, 16'hffff, 2'h0);
		rd(8'h08, 2'h0, 16'h3f1f);
		for (i = 0; i < 16; i++)
		begin
			r = rnd();
			md = r[15:0] & 16'h3f1f;
			md[9:8] = i[1:0];
			if (i == 1) md = 16'h0000;
			wr(8'h08, md, 2'h0);
			rf = rf & md[10];
			rd(8'h08, 2'h0, md);
			if_locked <= r[16];
			pat <= r[25:17];
			go <= 1;
			@(posedge ref_clk);
			go <= 0;
			repeat (4) @(posedge ref_clk);
			rd(8'h04, 2'h0, st_exp(md));
			status_read_clr <= 1;
			new_data_clr <= 6'h3f;
			@(posedge ref_clk);
			status_read_clr <= 0;
			new_data_clr <= 6'h00;
		end
		test_done(0);
	end
endmodule
`default_nettype wire
